// [hw/ptiu_top.sv]
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ptiu_defs.svh"
module ptiu_top
  import ptiu_pkg::*;
#(
  parameter int TICK_DIV = `PTIU_TICK_DIV
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // AXI4-Lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // AXI4-Lite read data
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // First eight-line port
  input  wire logic [7:0]  pa_i,
  output logic      [7:0]  pa_o,
  output logic      [7:0]  pa_oe,
  // Second eight-line port
  input  wire logic [7:0]  pb_i,
  output logic      [7:0]  pb_o,
  output logic      [7:0]  pb_oe,
  // First three-line port
  input  wire logic [2:0]  pc_i,
  output logic      [2:0]  pc_o,
  output logic      [2:0]  pc_oe,
  // Second three-line port
  input  wire logic [2:0]  pd_i,
  output logic      [2:0]  pd_o,
  output logic      [2:0]  pd_oe,
  // Serial bits
  input  wire logic        serial_in_line,
  output logic             serial_out_line,
  // Trap source, timer and interrupt
  input  wire logic        user_irq_n,
  output logic             timer_out,
  output logic             irq,
  output logic      [7:0]  irq_vector
);

  // True for the two handshaking modes
  function automatic logic is_strobed(input logic [1:0] m);
    return m == M8_SIN || m == M8_SOUT;
  endfunction : is_strobed

  // Two-stage synchroniser for every pin input
  logic [23:0] s1_q;
  logic [23:0] s2_q;
  wire  [23:0] pins_raw = {user_irq_n, serial_in_line, pd_i, pc_i,
                           pb_i, pa_i};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 24'hC00000;
      s2_q <= 24'hC00000;
    end else begin
      s1_q <= pins_raw;
      s2_q <= s1_q;
    end
  end

  // Write channel state
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        aw_full_q;
  logic        w_full_q;
  logic [7:0]  waddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  wire aw_take = awvalid && awready_q;
  wire w_take  = wvalid && wready_q;
  wire wr_go   = aw_full_q && w_full_q && !bvalid_q;
  wire b_done  = bvalid_q && bready;

  // Write decode and byte-lane masking
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                       {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wval  = wdata_q & wmask;
  wire wr_mode = wr_go && waddr_q == `PTIU_A_MODE;
  wire wr_tlen = wr_go && waddr_q == `PTIU_A_TLEN;
  wire wr_iclr = wr_go && waddr_q == `PTIU_A_ICLR;
  wire wr_ien  = wr_go && waddr_q == `PTIU_A_IEN;
  wire wr_ser  = wr_go && waddr_q == `PTIU_A_SER;
  wire wr_map  = waddr_q == `PTIU_A_MODE || waddr_q == `PTIU_A_PA ||
                 waddr_q == `PTIU_A_PB || waddr_q == `PTIU_A_PC ||
                 waddr_q == `PTIU_A_PD || waddr_q == `PTIU_A_TLEN ||
                 waddr_q == `PTIU_A_TCNT || waddr_q == `PTIU_A_IST ||
                 waddr_q == `PTIU_A_ICLR || waddr_q == `PTIU_A_IEN ||
                 waddr_q == `PTIU_A_IVEC || waddr_q == `PTIU_A_SER ||
                 waddr_q == `PTIU_A_PST;

  // Address and data are taken in either order; answer follows both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `PTIU_RESP_OKAY;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
        waddr_q <= awaddr;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? `PTIU_RESP_OKAY : `PTIU_RESP_SLVERR;
      end
      if (b_done) begin
        bvalid_q <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Software-owned control registers, plus the status and trap-pin history flops
  logic [7:0]  mode_q;
  logic [13:0] tlen_q;
  logic [3:0]  en_q;
  logic [3:0]  stat_q;
  logic        sout_q;
  logic        nmi_q;
  wire  [13:0] tlen_new = (tlen_q & ~wmask[13:0]) | wval[13:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= `PTIU_RST_MODE;
      tlen_q <= `PTIU_RST_TLEN;
      en_q <= `PTIU_RST_IEN;
      sout_q <= 1'b1;
    end else begin
      if (wr_mode) mode_q <= (mode_q & ~wmask[7:0]) | wval[7:0];
      if (wr_tlen) tlen_q <= tlen_new;
      if (wr_ien) en_q <= (en_q & ~wmask[3:0]) | wval[3:0];
      if (wr_ser) sout_q <= wval[0];
    end
  end

  // Trap input can never be masked
  wire [3:0] en_eff = en_q | `PTIU_NMI_MASK;
  wire [3:0] pend   = stat_q & en_eff;

  // Port slices; the small ports follow their large partner
  wire [1:0][7:0] p8o;
  wire [1:0][7:0] p8oe;
  wire [1:0][2:0] p3o;
  wire [1:0][2:0] p3oe;
  wire [1:0][7:0] rd8;
  wire [1:0][2:0] rd3;
  wire [1:0]      ev8;
  wire [1:0]      bf8;
  wire            rd_take = arvalid && arready;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_port
      localparam int IB = g ? `PTIU_IRQ_P2 : `PTIU_IRQ_P1;
      wire [1:0] m    = g ? mode_q[`PTIU_F_MB +: 2] : mode_q[`PTIU_F_MA +: 2];
      wire       sout = g ? mode_q[`PTIU_F_MD] : mode_q[`PTIU_F_MC];
      wire [7:0] pin  = g ? s2_q[15:8] : s2_q[7:0];
      wire [2:0] cpin = g ? s2_q[21:19] : s2_q[18:16];
      wire [7:0] a8   = g ? `PTIU_A_PB : `PTIU_A_PA;
      wire [7:0] a3   = g ? `PTIU_A_PD : `PTIU_A_PC;
      wire       wr8  = wr_go && waddr_q == a8;
      wire       wr3  = wr_go && waddr_q == a3;
      wire       rdp  = rd_take && araddr == a8;
      wire       ctl  = is_strobed(m);
      wire       intr = pend[IB];
      logic [7:0] dlat_q;
      logic [7:0] ilat_q;
      logic [2:0] clat_q;
      logic       bf_q;
      logic       stb_q;
      logic [7:0] oe8_q;
      logic [2:0] o3_q;
      logic [2:0] oe3_q;
      // Strobe is line 2 of the partner small port
      wire stb_rise = cpin[2] && !stb_q;
      wire stb_fall = !cpin[2] && stb_q;
      // Set wins over clear on buffer-full
      wire bf_d = (m == M8_SIN)  ? (stb_fall || (bf_q && !rdp)) :
                  (m == M8_SOUT) ? (wr8 || (bf_q && !stb_rise)) : 1'b0;

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          dlat_q <= 8'h00;
          ilat_q <= 8'h00;
          clat_q <= 3'h0;
          bf_q <= 1'b0;
          stb_q <= 1'b1;
          oe8_q <= 8'h00;
          o3_q <= 3'h0;
          oe3_q <= 3'h0;
        end else begin
          stb_q <= cpin[2];
          bf_q <= bf_d;
          if (wr8) dlat_q <= (dlat_q & ~wmask[7:0]) | wval[7:0];
          if (wr3) clat_q <= (clat_q & ~wmask[2:0]) | wval[2:0];
          if (m == M8_SIN && stb_fall) ilat_q <= pin;
          oe8_q <= {8{m == M8_OUT || m == M8_SOUT}};
          o3_q <= ctl ? {1'b0, bf_q, intr} : clat_q;
          oe3_q <= ctl ? 3'b011 : {3{sout}};
        end
      end

      assign p8o[g]  = dlat_q;
      assign p8oe[g] = oe8_q;
      assign p3o[g]  = o3_q;
      assign p3oe[g] = oe3_q;
      assign ev8[g]  = stb_rise && ctl;
      assign bf8[g]  = bf_q;
      assign rd8[g]  = (m == M8_IN) ? pin :
                       (m == M8_SIN) ? ilat_q : dlat_q;
      assign rd3[g]  = ctl ? {cpin[2], bf_q, intr} :
                       sout ? clat_q : cpin;
    end
  endgenerate

  // Timer core
  logic [13:0] tcnt;
  logic        tout;
  logic        tdone;
  logic        trun;
  ptiu_timer #(
    .TICK_DIV (TICK_DIV)
  ) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (wr_tlen),
    .len     (tlen_new),
    .func    (mode_q[`PTIU_F_TF +: 2]),
    .cnt_q   (tcnt),
    .out_q   (tout),
    .done_q  (tdone),
    .run_q   (trun)
  );

  // Sticky status; an event beats a clear in the same cycle
  wire       nmi_fall = nmi_q && !s2_q[23];
  wire [3:0] ev_set;
  assign ev_set[`PTIU_IRQ_NMI] = nmi_fall;
  assign ev_set[`PTIU_IRQ_TMR] = tdone;
  assign ev_set[`PTIU_IRQ_P2]  = ev8[1];
  assign ev_set[`PTIU_IRQ_P1]  = ev8[0];
  wire [3:0] ev_clr = wr_iclr ? wval[3:0] : 4'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 4'h0;
      nmi_q <= 1'b1;
    end else begin
      nmi_q <= s2_q[23];
      stat_q <= ev_set | (stat_q & ~ev_clr);
    end
  end

  // Priority and vector
  ptiu_intc u_intc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pend    (pend),
    .irq_q   (irq),
    .vec_q   (irq_vector)
  );

  // Read path; count is sampled live, never frozen
  wire [31:0] rd_mux =
    (araddr == `PTIU_A_MODE) ? {24'h0, mode_q} :
    (araddr == `PTIU_A_PA)   ? {24'h0, rd8[0]} :
    (araddr == `PTIU_A_PB)   ? {24'h0, rd8[1]} :
    (araddr == `PTIU_A_PC)   ? {29'h0, rd3[0]} :
    (araddr == `PTIU_A_PD)   ? {29'h0, rd3[1]} :
    (araddr == `PTIU_A_TLEN) ? {18'h0, tlen_q} :
    (araddr == `PTIU_A_TCNT) ? {18'h0, tcnt} :
    (araddr == `PTIU_A_IST)  ? {28'h0, stat_q} :
    (araddr == `PTIU_A_IEN)  ? {28'h0, en_eff} :
    (araddr == `PTIU_A_IVEC) ? {23'h0, irq, irq_vector} :
    (araddr == `PTIU_A_SER)  ? {30'h0, s2_q[22], sout_q} :
    (araddr == `PTIU_A_PST)  ? {28'h0, tout, trun, bf8} : 32'h00000000;
  wire rd_ok = araddr == `PTIU_A_MODE || araddr == `PTIU_A_PA ||
               araddr == `PTIU_A_PB || araddr == `PTIU_A_PC ||
               araddr == `PTIU_A_PD || araddr == `PTIU_A_TLEN ||
               araddr == `PTIU_A_TCNT || araddr == `PTIU_A_IST ||
               araddr == `PTIU_A_ICLR || araddr == `PTIU_A_IEN ||
               araddr == `PTIU_A_IVEC || araddr == `PTIU_A_SER ||
               araddr == `PTIU_A_PST;

  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `PTIU_RESP_OKAY;
    end else begin
      if (rd_take) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_ok ? `PTIU_RESP_OKAY : `PTIU_RESP_SLVERR;
      end
      if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // Outputs, all flop-driven
  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign pa_o    = p8o[0];
  assign pa_oe   = p8oe[0];
  assign pb_o    = p8o[1];
  assign pb_oe   = p8oe[1];
  assign pc_o    = p3o[0];
  assign pc_oe   = p3oe[0];
  assign pd_o    = p3o[1];
  assign pd_oe   = p3oe[1];
  assign serial_out_line = sout_q;
  assign timer_out = tout;

endmodule : ptiu_top
`default_nettype wire

// [hw/ptiu_defs.svh]
`ifndef PTIU_DEFS_SVH
`define PTIU_DEFS_SVH

// Register byte offsets
`define PTIU_A_MODE 8'h00
`define PTIU_A_PA   8'h04
`define PTIU_A_PB   8'h08
`define PTIU_A_PC   8'h0C
`define PTIU_A_PD   8'h10
`define PTIU_A_TLEN 8'h14
`define PTIU_A_TCNT 8'h18
`define PTIU_A_IST  8'h1C
`define PTIU_A_ICLR 8'h20
`define PTIU_A_IEN  8'h24
`define PTIU_A_IVEC 8'h28
`define PTIU_A_SER  8'h2C
`define PTIU_A_PST  8'h30

// Mode register fields
`define PTIU_F_MA 0
`define PTIU_F_MB 2
`define PTIU_F_MC 4
`define PTIU_F_MD 5
`define PTIU_F_TF 6

// Reset values
`define PTIU_RST_MODE 8'h00
`define PTIU_RST_IEN  4'h1
`define PTIU_RST_TLEN 14'h0002

// Interrupt status bit positions
`define PTIU_IRQ_NMI 0
`define PTIU_IRQ_TMR 1
`define PTIU_IRQ_P2  2
`define PTIU_IRQ_P1  3
`define PTIU_NMI_MASK 4'h1

// Vector addresses
`define PTIU_VEC_NMI 8'h26
`define PTIU_VEC_75  8'h3C
`define PTIU_VEC_65  8'h34
`define PTIU_VEC_55  8'h2C

// Timer reference
`define PTIU_CLK_HZ   125000000
`define PTIU_REF_HZ   122880
`define PTIU_TICK_DIV (`PTIU_CLK_HZ / `PTIU_REF_HZ)

// Bus answers
`define PTIU_RESP_OKAY   2'h0
`define PTIU_RESP_SLVERR 2'h2

`endif

// [hw/ptiu_pkg.sv]
package ptiu_pkg;

  // Eight-line port modes
  typedef enum logic [1:0] {
    M8_IN   = 2'h0,
    M8_OUT  = 2'h1,
    M8_SIN  = 2'h2,
    M8_SOUT = 2'h3
  } ptiu_mode8_t;

  // Timer output functions
  typedef enum logic [1:0] {
    TF_PULSE  = 2'h0,
    TF_SQUARE = 2'h1,
    TF_RATE   = 2'h2,
    TF_STROBE = 2'h3
  } ptiu_tfunc_t;

  // Timer states
  typedef enum logic [1:0] {
    TS_IDLE = 2'b01,
    TS_RUN  = 2'b10
  } ptiu_tstate_t;

endpackage : ptiu_pkg

// [hw/ptiu_timer.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ptiu_defs.svh"
module ptiu_timer
  import ptiu_pkg::*;
#(
  parameter int TICK_DIV = `PTIU_TICK_DIV
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Control
  input  wire logic        load,
  input  wire logic [13:0] len,
  input  wire logic [1:0]  func,
  // State
  output logic      [13:0] cnt_q,
  output logic             out_q,
  output logic             done_q,
  output logic             run_q
);

  localparam int PW = $clog2(TICK_DIV + 1);

  ptiu_tstate_t st_q;
  logic [PW-1:0] pre_q;
  logic [13:0]   len_q;
  logic [1:0]    func_q;

  // Output shape for a given remaining count
  function automatic logic shape(input logic [1:0] f, input logic [13:0] c,
                                 input logic [13:0] l);
    if (f == TF_RATE || f == TF_STROBE) begin
      return c != 14'h0001;
    end
    return c > (l >> 1);
  endfunction : shape

  // Counts below two cannot be split in halves
  wire [13:0] len_ok = (len < 14'h0002) ? 14'h0002 : len;
  wire        tick   = pre_q == PW'(TICK_DIV - 1);
  wire        tc     = cnt_q == 14'h0001;
  wire        oneshot = func_q == TF_PULSE || func_q == TF_STROBE;
  wire [13:0] nxt    = tc ? len_q : cnt_q - 14'h0001;

  // Down counter and output function
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= TS_IDLE;
      pre_q <= '0;
      cnt_q <= 14'h0000;
      len_q <= `PTIU_RST_TLEN;
      func_q <= 2'h0;
      out_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      pre_q <= tick ? '0 : pre_q + PW'(1);
      if (load) begin
        st_q <= TS_RUN;
        pre_q <= '0;
        cnt_q <= len_ok;
        len_q <= len_ok;
        func_q <= func;
        out_q <= shape(func, len_ok, len_ok);
      end else begin
        case (st_q)
          TS_RUN: begin
            if (tick) begin
              done_q <= tc;
              if (tc && oneshot) begin
                st_q <= TS_IDLE;
                out_q <= 1'b1;
              end else begin
                cnt_q <= nxt;
                out_q <= shape(func_q, nxt, len_q);
              end
            end
          end
          default: out_q <= 1'b1;
        endcase
      end
    end
  end

  assign run_q = st_q == TS_RUN;

endmodule : ptiu_timer
`default_nettype wire

// [hw/ptiu_intc.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ptiu_defs.svh"
module ptiu_intc
  import ptiu_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Enabled pending requests
  input  wire logic [3:0] pend,
  // Request and vector
  output logic            irq_q,
  output logic      [7:0] vec_q
);

  // Fixed priority, trap highest
  wire [7:0] vec_d = pend[`PTIU_IRQ_NMI] ? `PTIU_VEC_NMI :
                     pend[`PTIU_IRQ_TMR] ? `PTIU_VEC_75 :
                     pend[`PTIU_IRQ_P2]  ? `PTIU_VEC_65 :
                     pend[`PTIU_IRQ_P1]  ? `PTIU_VEC_55 : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
      vec_q <= 8'h00;
    end else begin
      irq_q <= |pend;
      vec_q <= vec_d;
    end
  end

endmodule : ptiu_intc
`default_nettype wire

// [test/ptiu_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module ptiu_properties (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Bus handshakes
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic       bvalid,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  // Port enables
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pb_oe,
  input wire logic [2:0] pc_oe,
  input wire logic [2:0] pd_oe,
  // Interrupts
  input wire logic       user_irq_n,
  input wire logic       irq,
  input wire logic [7:0] irq_vector
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_port_whole: assert property (pa_oe inside {8'h00, 8'hFF} &&
    pb_oe inside {8'h00, 8'hFF}) else $error("eight-line port split");
  a_small_oe: assert property (pc_oe inside {3'h0, 3'h3, 3'h7} &&
    pd_oe inside {3'h0, 3'h3, 3'h7}) else $error("small port enable bad");
  a_vec_legal: assert property (irq_vector inside
    {8'h00, 8'h26, 8'h3C, 8'h34, 8'h2C}) else $error("vector not legal");
  a_vec_irq: assert property ((irq_vector != 8'h00) == irq)
    else $error("vector and request disagree");
  a_trap_wins: assert property ($fell(user_irq_n) |->
    ##[2:8] (irq && irq_vector == 8'h26)) else $error("trap not taken");
  a_write_answer: assert property (awvalid && awready && wvalid && wready
    |-> ##2 bvalid) else $error("write answer late");
  a_read_answer: assert property (arvalid && arready |=> rvalid ##0
    !arready) else $error("read answer late");
  a_write_busy: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while answering");
endmodule : ptiu_properties
`default_nettype wire

// [test/ptiu_periph.sv]
`timescale 1ns/100ps
`default_nettype none
module ptiu_periph (
  // Clock
  input  wire logic       aclk,
  // Unit drive
  input  wire logic [7:0] pa_o,
  input  wire logic [7:0] pa_oe,
  input  wire logic [7:0] pb_o,
  input  wire logic [7:0] pb_oe,
  input  wire logic [2:0] pc_o,
  input  wire logic [2:0] pc_oe,
  input  wire logic [2:0] pd_o,
  input  wire logic [2:0] pd_oe,
  // Line levels
  output logic      [7:0] pa_i,
  output logic      [7:0] pb_i,
  output logic      [2:0] pc_i,
  output logic      [2:0] pd_i
);
  logic [7:0] ext_a = 8'h00;
  logic [7:0] ext_b = 8'h00;
  logic [2:0] ext_c = 3'h4;
  logic [2:0] ext_d = 3'h4;
  // A line shows the unit where it drives, otherwise us
  assign pa_i = (pa_oe & pa_o) | (~pa_oe & ext_a);
  assign pb_i = (pb_oe & pb_o) | (~pb_oe & ext_b);
  assign pc_i = (pc_oe & pc_o) | (~pc_oe & ext_c);
  assign pd_i = (pd_oe & pd_o) | (~pd_oe & ext_d);

  // Present a byte; with stb, pulse control line 2 low
  task automatic put(input int p, input logic [7:0] d, input bit stb);
    if (p == 0) ext_a <= d;
    else ext_b <= d;
    if (stb) begin
      repeat (3) @(posedge aclk);
      if (p == 0) ext_c[2] <= 1'b0;
      else ext_d[2] <= 1'b0;
      repeat (4) @(posedge aclk);
      if (p == 0) ext_c[2] <= 1'b1;
      else ext_d[2] <= 1'b1;
      repeat (4) @(posedge aclk);
      // Data is not held after the strobe, so show its inverse
      if (p == 0) ext_a <= ~d;
      else ext_b <= ~d;
    end
    @(posedge aclk);
  endtask : put
endmodule : ptiu_periph
`default_nettype wire

// [test/port_timer_interrupt_unit_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ptiu_defs.svh"
module port_timer_interrupt_unit_tb;
  localparam int TD = 2;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic serial_in_line, user_irq_n, awready, wready, bvalid, arready;
  logic rvalid, serial_out_line, timer_out, irq;
  logic [7:0] awaddr, araddr, irq_vector, pa_i, pa_o, pa_oe;
  logic [7:0] pb_i, pb_o, pb_oe;
  logic [2:0] pc_i, pc_o, pc_oe, pd_i, pd_o, pd_oe;
  logic [31:0] wdata, rdata, rd_q, a, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp_q;
  logic [31:0] seed = 32'h6D83;
  int errors = 0;
  int samples_checked = 0;
  int lo, hi, elo, ehi;

  ptiu_top #(.TICK_DIV(TD)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pa_i(pa_i), .pa_o(pa_o), .pa_oe(pa_oe),
    .pb_i(pb_i), .pb_o(pb_o), .pb_oe(pb_oe), .pc_i(pc_i), .pc_o(pc_o),
    .pc_oe(pc_oe), .pd_i(pd_i), .pd_o(pd_o), .pd_oe(pd_oe),
    .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
    .user_irq_n(user_irq_n), .timer_out(timer_out), .irq(irq),
    .irq_vector(irq_vector));
  ptiu_periph periph_u (.aclk(aclk), .pa_o(pa_o), .pa_oe(pa_oe),
    .pb_o(pb_o), .pb_oe(pb_oe), .pc_o(pc_o), .pc_oe(pc_oe), .pd_o(pd_o),
    .pd_oe(pd_oe), .pa_i(pa_i), .pb_i(pb_i), .pc_i(pc_i), .pd_i(pd_i));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // Bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    bit aw_t, w_t;
    aw_t = 0;
    w_t = 0;
    awaddr <= ad;
    wdata <= dt;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_t && w_t)) begin
      @(posedge aclk);
      if (awvalid && awready) begin aw_t = 1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w_t = 1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (!bvalid);
    rsp_q = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] ad);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd_q = rdata;
    rsp_q = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // Timer output widths: wait for a fall, count low, then count high
  task automatic meas();
    hi = 0;
    lo = 0;
    while (timer_out !== 1'b0 && hi < 200) begin @(posedge aclk); hi++; end
    hi = 0;
    while (timer_out === 1'b0 && lo < 200) begin @(posedge aclk); lo++; end
    while (timer_out === 1'b1 && hi < 60) begin @(posedge aclk); hi++; end
  endtask : meas

  initial begin
    #(8 * 20000);
    errors++;
    results();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, serial_in_line} = '0;
    user_irq_n = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(timer_out, 1'b1);
    rd(`PTIU_A_MODE); chk(rd_q, 0);
    rd(`PTIU_A_IEN); chk(rd_q, 1);
    rd(`PTIU_A_TLEN); chk(rd_q, 2);
    rd(8'h3C); chk(rd_q, 0); chk(rsp_q, `PTIU_RESP_SLVERR);
    wr(8'h3C, rnd()); chk(rsp_q, `PTIU_RESP_SLVERR);
    // Every mode of both large ports, small ports asked to be outputs
    for (int p = 0; p < 2; p++) for (int m = 0; m < 4; m++) begin
      wr(`PTIU_A_MODE, (m << (2 * p)) | 32'h30);
      repeat (2) @(posedge aclk);
      chk(p ? pb_oe : pa_oe, (m % 2) ? 8'hFF : 8'h00);
      chk(p ? pd_oe : pc_oe, (m > 1) ? 3'h3 : 3'h7);
    end
    // Unlatched input, latched output, then strobed input per port
    for (int p = 0; p < 2; p++) begin
      d = rnd();
      wr(`PTIU_A_MODE, 0);
      periph_u.put(p, d[7:0], 0);
      repeat (4) @(posedge aclk);
      rd(8'h04 + 4 * p); chk(rd_q, d[7:0]);
      wr(`PTIU_A_MODE, 1 << (2 * p));
      wr(8'h04 + 4 * p, d);
      chk(p ? pb_o : pa_o, d[7:0]);
      wr(`PTIU_A_MODE, 2 << (2 * p));
      // Mode sweeps above leave stray strobe events behind
      wr(`PTIU_A_ICLR, 15);
      wr(`PTIU_A_IEN, 1 | (8 >> p));
      periph_u.put(p, ~d[7:0], 1);
      chk(p ? pd_o : pc_o, 3'h3);
      rd(8'h04 + 4 * p); chk(rd_q, ~d[7:0] & 8'hFF);
      chk(irq_vector, p ? 8'h34 : 8'h2C);
      wr(`PTIU_A_ICLR, 8 >> p);
      // Strobed output: a data write fills, the strobe empties
      wr(`PTIU_A_MODE, 3 << (2 * p));
      wr(8'h04 + 4 * p, d);
      chk(p ? pd_o[1] : pc_o[1], 1'b1);
      periph_u.put(p, d[7:0], 1);
      chk(p ? pd_o : pc_o, 3'h1);
      rd(`PTIU_A_IST); chk(rd_q, 8 >> p);
      wr(`PTIU_A_ICLR, 8 >> p);
    end
    // Four timer functions at length 8, widths from the count rules
    for (int f = 0; f < 4; f++) begin
      wr(`PTIU_A_MODE, f << 6);
      wr(`PTIU_A_IEN, 3);
      wr(`PTIU_A_TLEN, 8);
      // Cleared after the load so a running square wave cannot pre-set it
      wr(`PTIU_A_ICLR, 2);
      meas();
      elo = (f < 2) ? 4 * TD : TD;
      ehi = (f == 1) ? 4 * TD : (f == 2) ? 7 * TD : 60;
      chk(lo, elo);
      chk(hi, ehi);
      chk(irq_vector, 8'h3C);
      if (f == 1) begin
        rd(`PTIU_A_TCNT);
        a = rd_q;
        rd(`PTIU_A_TCNT);
        chk(rd_q[13:0] <= 14'd8 && rd_q !== a, 1'b1);
      end
    end
    // Masking, trap priority and unmaskable trap
    wr(`PTIU_A_IEN, 0);
    wr(`PTIU_A_ICLR, 15);
    // Square wave keeps setting the masked timer status
    wr(`PTIU_A_MODE, 1 << 6);
    wr(`PTIU_A_TLEN, 8);
    rd(`PTIU_A_IEN); chk(rd_q, 1);
    repeat (30) @(posedge aclk);
    chk(irq, 1'b0);
    rd(`PTIU_A_IST); chk(rd_q[1], 1'b1);
    user_irq_n <= 1'b0; // Catastrophic event from outside
    repeat (8) @(posedge aclk);
    chk({irq, irq_vector}, {1'b1, 8'h26});
    wr(`PTIU_A_IEN, 2);
    chk(irq_vector, 8'h26);
    wr(`PTIU_A_ICLR, 1);
    repeat (3) @(posedge aclk);
    chk(irq_vector, 8'h3C);
    user_irq_n <= 1'b1;
    // Serial bits are plain software bits
    wr(`PTIU_A_SER, 0);
    chk(serial_out_line, 1'b0);
    serial_in_line <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(`PTIU_A_SER); chk(rd_q[1:0], 2'h2);
    results();
  end
endmodule : port_timer_interrupt_unit_tb

bind ptiu_top ptiu_properties chk_u (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .pa_oe(pa_oe), .pb_oe(pb_oe), .pc_oe(pc_oe), .pd_oe(pd_oe),
  .user_irq_n(user_irq_n), .irq(irq), .irq_vector(irq_vector));
`default_nettype wire
